// ### verilog/extra_ext_interrupts_port.sv
// Added external interrupts and auxiliary 4-bit port
// Notes on behaviour
// R1 - Control register at SFR 0C0H; every bit settable and clearable singly. In level mode bits 1 and 5 follow the pins, so bit writes to them are lost.
// R2 - Bit address 0C2H selects irq A enable; control bit 0 is 0C0H.
// R3 - Each added interrupt requests service only while its enable is set.
// R4 - Priority bit set puts the interrupt in the high level.
// R5 - Edge-select 1 means falling edge, 0 means low level; software only.
// R6 - Edge mode: hardware sets pending on edge, clears it on vectoring.
// R7 - Interrupt A vectors to 33H at polling position 6.
// R8 - Interrupt B vectors to 3BH at polling position 7, lowest.
// R9 - Fixed order in a level: six base sources first, then A, then B.
// R10 - Auxiliary port at SFR 0D8H; only bits 3..0 are pins.
// R11 - Port acts as general port; bits 3 and 2 double as interrupt inputs.
// R12 - Write drives pins, read returns pins, read-modify-write changes latch.
// R13 - Pins are pulled-up quasi-bidirectional; latch 1 lets pin be input.
// R14 - Reset sets port latch to all ones, control register to zero.
// R15 - Pin mapping is a parameter; edge-select bits sit at 0 and 4.
// R16 - Falling edge is a synchronised high sample followed by a low one.
`timescale 1ns/100ps
module extra_ext_interrupts_port #(
  parameter int PIN_A = xirq_pkg::PIN_A_DEFAULT,
  parameter int PIN_B = xirq_pkg::PIN_B_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  input wire logic [7:0] bit_addr,
  input wire logic bit_wdata,
  input wire logic bit_wr,
  input wire logic bit_rd,
  output logic [7:0] sfr_rdata,
  output logic bit_rdata,
  input wire logic [3:0] aux_pin_i,
  output logic [3:0] aux_pin_o,
  output logic [3:0] aux_pin_oe,
  input wire logic vector_ack_a,
  input wire logic vector_ack_b,
  output logic irq_a_req,
  output logic irq_b_req,
  output logic irq_a_high_prio,
  output logic irq_b_high_prio,
  output logic [7:0] irq_a_vector,
  output logic [7:0] irq_b_vector,
  output logic [2:0] irq_a_poll,
  output logic [2:0] irq_b_poll
);

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] latch_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [1:0] prev_q;

  // Bit address -> byte base and bit index
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
    hit = (a[7:3] == base[7:3]);
  endfunction

  wire ctrl_byte_wr = sfr_wr && (sfr_addr == xirq_pkg::ADDR_CONTROL);
  wire port_byte_wr = sfr_wr && (sfr_addr == xirq_pkg::ADDR_AUX_PORT);
  wire ctrl_bit_wr = bit_wr && hit(bit_addr, xirq_pkg::ADDR_CONTROL); // [R2]
  wire port_bit_wr = bit_wr && hit(bit_addr, xirq_pkg::ADDR_AUX_PORT);
  wire [2:0] bidx = bit_addr[2:0];

  // ------------------------------------------------------------
  // Pin synchroniser and edge detect
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_q <= xirq_pkg::AUX_PINS_RST;
      sync2_q <= xirq_pkg::AUX_PINS_RST;
    end
    else
    begin
      sync1_q <= aux_pin_i;
      sync2_q <= sync1_q;
    end
  end

  wire lvl_a_n = sync2_q[PIN_A]; // [R11] [R15]
  wire lvl_b_n = sync2_q[PIN_B]; // [R11] [R15]

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      prev_q <= 2'h3;
    else
      prev_q <= {lvl_b_n, lvl_a_n};
  end

  wire fall_a = prev_q[0] && !lvl_a_n; // [R16]
  wire fall_b = prev_q[1] && !lvl_b_n; // [R16]

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  logic [7:0] ctrl_d;
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (ctrl_byte_wr)
      ctrl_d = sfr_wdata;
    if (ctrl_bit_wr)
      ctrl_d[bidx] = bit_wdata; // [R1]
    // Edge mode pending: vectoring clears, new edge wins over clear
    if (ctrl_q[xirq_pkg::BIT_A_EDGE])
    begin
      if (vector_ack_a)
        ctrl_d[xirq_pkg::BIT_A_PEND] = 1'b0; // [R6]
      if (fall_a)
        ctrl_d[xirq_pkg::BIT_A_PEND] = 1'b1; // [R5] [R6]
    end
    else
      ctrl_d[xirq_pkg::BIT_A_PEND] = !lvl_a_n; // [R5]
    if (ctrl_q[xirq_pkg::BIT_B_EDGE])
    begin
      if (vector_ack_b)
        ctrl_d[xirq_pkg::BIT_B_PEND] = 1'b0; // [R6]
      if (fall_b)
        ctrl_d[xirq_pkg::BIT_B_PEND] = 1'b1; // [R5] [R6]
    end
    else
      ctrl_d[xirq_pkg::BIT_B_PEND] = !lvl_b_n; // [R5]
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      ctrl_q <= xirq_pkg::RST_CONTROL; // [R14]
    else
      ctrl_q <= ctrl_d; // [R1]
  end

  // ------------------------------------------------------------
  // Auxiliary port latch
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      latch_q <= xirq_pkg::RST_AUX_PORT; // [R14]
    else if (port_byte_wr)
      latch_q <= sfr_wdata; // [R12]
    else if (port_bit_wr)
      latch_q[bidx] <= bit_wdata; // [R10]
  end

  // Quasi-bidirectional: only drive low; pull-up makes a 1 an input
  assign aux_pin_o = '0;
  assign aux_pin_oe = ~latch_q[3:0]; // [R13]

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  // Read-modify-write reads the latch so unselected bits keep value
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sfr_rdata <= 8'h00;
      bit_rdata <= 1'b0;
    end
    else
    begin
      sfr_rdata <= 8'h00;
      if (sfr_rd && sfr_addr == xirq_pkg::ADDR_CONTROL)
        sfr_rdata <= ctrl_q;
      else if (sfr_rd && sfr_addr == xirq_pkg::ADDR_AUX_PORT)
        sfr_rdata <= sfr_rmw ? latch_q : {4'hF, sync2_q}; // [R12] [R10]
      bit_rdata <= 1'b0;
      if (bit_rd && hit(bit_addr, xirq_pkg::ADDR_CONTROL))
        bit_rdata <= ctrl_q[bidx];
      else if (bit_rd && hit(bit_addr, xirq_pkg::ADDR_AUX_PORT))
        bit_rdata <= (bidx < 3'h4) ? sync2_q[bidx[1:0]] : 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Requests to the core
  // ------------------------------------------------------------
  assign irq_a_req = ctrl_q[xirq_pkg::BIT_A_PEND]
    && ctrl_q[xirq_pkg::BIT_A_EN]; // [R3]
  assign irq_b_req = ctrl_q[xirq_pkg::BIT_B_PEND]
    && ctrl_q[xirq_pkg::BIT_B_EN]; // [R3]
  assign irq_a_high_prio = ctrl_q[xirq_pkg::BIT_A_PRIO]; // [R4]
  assign irq_b_high_prio = ctrl_q[xirq_pkg::BIT_B_PRIO]; // [R4]
  // Core places these after its six own sources in each level
  assign irq_a_vector = xirq_pkg::VEC_IRQ_A; // [R7] [R9]
  assign irq_b_vector = xirq_pkg::VEC_IRQ_B; // [R8] [R9]
  assign irq_a_poll = xirq_pkg::POLL_IRQ_A; // [R7]
  assign irq_b_poll = xirq_pkg::POLL_IRQ_B; // [R8]

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_fall_a;
    ctrl_q[xirq_pkg::BIT_A_EDGE] && fall_a;
  endsequence

  a_edge_sets_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_fall_a |=> ctrl_q[xirq_pkg::BIT_A_PEND]) // [R6]
    else $error("edge did not set pending A");
  a_ack_clears_b: assert property (@(posedge clk_sys) disable iff (!nrst)
    ctrl_q[xirq_pkg::BIT_B_EDGE] && vector_ack_b && !fall_b && !ctrl_bit_wr
    && !ctrl_byte_wr |=> !ctrl_q[xirq_pkg::BIT_B_PEND]) // [R6]
    else $error("vectoring did not clear pending B");
  a_level_follows_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !ctrl_q[xirq_pkg::BIT_A_EDGE] && !ctrl_d[xirq_pkg::BIT_A_EDGE]
    ##1 !ctrl_q[xirq_pkg::BIT_A_EDGE] |->
    ctrl_q[xirq_pkg::BIT_A_PEND] == !$past(lvl_a_n)) // [R5]
    else $error("level pending A does not follow pin");
  a_enable_gates: assert property (@(posedge clk_sys) disable iff (!nrst)
    irq_b_req |-> ctrl_q[xirq_pkg::BIT_B_EN]) // [R3]
    else $error("request B without enable");
  a_bit_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    ctrl_bit_wr && bidx == 3'h2 && !ctrl_byte_wr
    |=> ctrl_q[xirq_pkg::BIT_A_EN] == $past(bit_wdata)) // [R2]
    else $error("bit write to enable A lost");
  a_port_drive: assert property (@(posedge clk_sys) disable iff (!nrst)
    port_byte_wr |=> ##1 aux_pin_oe == ~$past(sfr_wdata[3:0], 2)) // [R12]
    else $error("port write not on pins");
  a_edge_detect: assert property (@(posedge clk_sys) disable iff (!nrst)
    ctrl_q[xirq_pkg::BIT_B_EDGE] && $fell(sync2_q[PIN_B])
    |=> ctrl_q[xirq_pkg::BIT_B_PEND]) // [R16]
    else $error("falling edge B missed");

  // ------------------------------------------------------------
  // Further checks
  // ------------------------------------------------------------
  sequence s_fall_b;
    ctrl_q[xirq_pkg::BIT_B_EDGE] && fall_b;
  endsequence

  sequence s_ack_a;
    ctrl_q[xirq_pkg::BIT_A_EDGE] && vector_ack_a && !fall_a
    && !ctrl_bit_wr && !ctrl_byte_wr;
  endsequence

  sequence s_level_b;
    !ctrl_q[xirq_pkg::BIT_B_EDGE] && !ctrl_d[xirq_pkg::BIT_B_EDGE]
    ##1 !ctrl_q[xirq_pkg::BIT_B_EDGE];
  endsequence

  // Edge flag must latch even while software writes the register
  a_edge_sets_b: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_fall_b |=> ctrl_q[xirq_pkg::BIT_B_PEND]) // [R6]
    else $error("edge did not set pending B");
  a_ack_clears_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_ack_a |=> !ctrl_q[xirq_pkg::BIT_A_PEND]) // [R6]
    else $error("vectoring did not clear pending A");

  // Level pending lags the synchronised pin by one cycle
  a_level_follows_b: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_level_b |->
    ctrl_q[xirq_pkg::BIT_B_PEND] == !$past(lvl_b_n)) // [R5]
    else $error("level pending B does not follow pin");
  a_level_ack_b: assert property (@(posedge clk_sys) disable iff (!nrst)
    !ctrl_q[xirq_pkg::BIT_B_EDGE] && !lvl_b_n |=> ctrl_q[xirq_pkg::BIT_B_PEND])
    else $error("low level B not pending"); // [R5]

  // First edge after release must still show reset contents
  a_reset_values: assert property (@(posedge clk_sys)
    $rose(nrst) |-> ctrl_q == xirq_pkg::RST_CONTROL
    && latch_q == xirq_pkg::RST_AUX_PORT) // [R14]
    else $error("reset values wrong");

  a_port_byte: assert property (@(posedge clk_sys) disable iff (!nrst)
    port_byte_wr |=> latch_q == $past(sfr_wdata)) // [R12]
    else $error("port byte write lost");
  a_port_bit: assert property (@(posedge clk_sys) disable iff (!nrst)
    port_bit_wr && !port_byte_wr
    |=> latch_q[$past(bidx)] == $past(bit_wdata)) // [R10]
    else $error("port bit write lost");

  // Read data stands for one cycle only
  a_read_control: assert property (@(posedge clk_sys) disable iff (!nrst)
    sfr_rd && sfr_addr == xirq_pkg::ADDR_CONTROL
    |=> sfr_rdata == $past(ctrl_q)) // [R1]
    else $error("control read wrong");
  a_read_unmapped: assert property (@(posedge clk_sys) disable iff (!nrst)
    sfr_rd && sfr_addr != xirq_pkg::ADDR_CONTROL
    && sfr_addr != xirq_pkg::ADDR_AUX_PORT
    |=> sfr_rdata == '0) // [R1]
    else $error("unmapped read not zero");
  a_bit_read: assert property (@(posedge clk_sys) disable iff (!nrst)
    bit_rd && hit(bit_addr, xirq_pkg::ADDR_CONTROL)
    |=> bit_rdata == $past(ctrl_q[bidx])) // [R2]
    else $error("control bit read wrong");

  // Added source A must poll before added source B
  a_poll_order: assert property (@(posedge clk_sys) disable iff (!nrst)
    irq_a_poll < irq_b_poll) // [R9]
    else $error("poll order wrong");

endmodule

// ### shared/xirq_pkg.sv
// Constants for the added-interrupt and auxiliary-port block
package xirq_pkg;
  localparam logic [7:0] ADDR_CONTROL = 8'hC0;
  localparam logic [7:0] ADDR_AUX_PORT = 8'hD8;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_AUX_PORT = 8'hFF;
  localparam logic [3:0] AUX_PINS_RST = 4'hF;
  localparam logic [7:0] VEC_IRQ_A = 8'h33;
  localparam logic [7:0] VEC_IRQ_B = 8'h3B;
  localparam logic [2:0] POLL_IRQ_A = 3'h6;
  localparam logic [2:0] POLL_IRQ_B = 3'h7;
  localparam int AUX_WIDTH = 4;
  localparam int BIT_A_EDGE = 0;
  localparam int BIT_A_PEND = 1;
  localparam int BIT_A_EN = 2;
  localparam int BIT_A_PRIO = 3;
  localparam int BIT_B_EDGE = 4;
  localparam int BIT_B_PEND = 5;
  localparam int BIT_B_EN = 6;
  localparam int BIT_B_PRIO = 7;
  localparam int PIN_A_DEFAULT = 2;
  localparam int PIN_B_DEFAULT = 3;
endpackage

// ### tb/irq_source_model.sv
// Pin-side model: pulled-up port pins and external interrupt sources
`timescale 1ns/100ps
module irq_source_model (
  input wire logic [3:0] aux_pin_o,
  input wire logic [3:0] aux_pin_oe,
  input wire logic [3:0] src_low,
  output logic [3:0] aux_pin_i
);
  // ----------------------------------------
  // Wired level
  // ----------------------------------------
  // Undriven pin floats to the pull-up; a source can only pull low
  assign aux_pin_i = ((aux_pin_oe & aux_pin_o) | ~aux_pin_oe) & ~src_low;
endmodule

// ### tb/extra_ext_interrupts_port_tb.sv
// Self-checking bench for the added interrupts and auxiliary port
`timescale 1ns/100ps
`define CHK(nm, e, g) \
  n_checks++; \
  if ((g) !== (e)) \
  begin \
    bad_count++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); \
  end
module extra_ext_interrupts_port_tb;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rmw = 1'b0, bit_wdata = 1'b0;
  logic bit_wr = 1'b0, ack_a = 1'b0, ack_b = 1'b0;
  logic bit_rd = 1'b0;
  logic [3:0] src_low = 4'h0;
  logic [7:0] sfr_rdata, rd_val, irq_a_vector, irq_b_vector;
  logic bit_rdata, irq_a_req, irq_b_req, irq_a_high_prio, irq_b_high_prio;
  logic [3:0] aux_pin_i, aux_pin_o, aux_pin_oe;
  logic [2:0] irq_a_poll, irq_b_poll;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  // ----------------------------------------
  // Clock, timeout, instances
  // ----------------------------------------
  always #20 clk_sys = ~clk_sys;
  // Whole run needs well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      finish_test();
    end
  end
  extra_ext_interrupts_port dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rmw(sfr_rmw), .bit_addr(bit_addr), .bit_wdata(bit_wdata),
    .bit_wr(bit_wr), .bit_rd(bit_rd), .sfr_rdata(sfr_rdata),
    .bit_rdata(bit_rdata), .aux_pin_i(aux_pin_i), .aux_pin_o(aux_pin_o),
    .aux_pin_oe(aux_pin_oe), .vector_ack_a(ack_a), .vector_ack_b(ack_b),
    .irq_a_req(irq_a_req), .irq_b_req(irq_b_req),
    .irq_a_high_prio(irq_a_high_prio), .irq_b_high_prio(irq_b_high_prio),
    .irq_a_vector(irq_a_vector), .irq_b_vector(irq_b_vector),
    .irq_a_poll(irq_a_poll), .irq_b_poll(irq_b_poll)
  );
  irq_source_model src_u (
    .aux_pin_o(aux_pin_o), .aux_pin_oe(aux_pin_oe),
    .src_low(src_low), .aux_pin_i(aux_pin_i)
  );
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
  endtask
  task automatic wr_bit(input logic [7:0] a, input logic v);
    @(posedge clk_sys);
    bit_addr <= a;
    bit_wdata <= v;
    bit_wr <= 1'b1;
    @(posedge clk_sys);
    bit_wr <= 1'b0;
  endtask
  // Read data is registered, so it is taken one step after the edge
  task automatic rd_byte(input logic [7:0] a, input logic rmw);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rmw <= rmw;
    sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    #1 rd_val = sfr_rdata;
  endtask
  task automatic rd_bit(input logic [7:0] a);
    @(posedge clk_sys);
    bit_addr <= a;
    bit_rd <= 1'b1;
    @(posedge clk_sys);
    bit_rd <= 1'b0;
    #1 rd_val = {7'h00, bit_rdata};
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd_byte(xirq_pkg::ADDR_CONTROL, 1'b0);
    `CHK("control", 8'h00, rd_val)
    rd_byte(xirq_pkg::ADDR_AUX_PORT, 1'b1);
    `CHK("latch", 8'hFF, rd_val)
    rd_byte(8'h55, 1'b0);
    `CHK("unmapped", 8'h00, rd_val)
  endtask
  task automatic t_bits();
    for (int i = 0; i < 8; i++)
      wr_bit(8'hC0 + 8'(i), 1'b1);
    wr_bit(8'hC2, 1'b0);
    rd_byte(xirq_pkg::ADDR_CONTROL, 1'b0);
    `CHK("control bits", 8'hFB, rd_val)
    rd_bit(8'hC2);
    `CHK("bit c2", 8'h00, rd_val)
    rd_bit(8'hC3);
    `CHK("bit c3", 8'h01, rd_val)
    `CHK("a masked", 1'b0, irq_a_req)
    `CHK("b req", 1'b1, irq_b_req)
    `CHK("b prio", 1'b1, irq_b_high_prio)
    wr_byte(xirq_pkg::ADDR_CONTROL, 8'h00);
  endtask
  task automatic t_port();
    wr_byte(xirq_pkg::ADDR_AUX_PORT, 8'h0A);
    #1 `CHK("oe", 4'h5, aux_pin_oe)
    `CHK("pin out", 4'h0, aux_pin_o)
    wait_cyc(2);
    rd_byte(xirq_pkg::ADDR_AUX_PORT, 1'b0);
    `CHK("pins", 8'hFA, rd_val)
    rd_bit(8'hD9);
    `CHK("pin bit 1", 8'h01, rd_val)
    rd_bit(8'hDD);
    `CHK("pin bit 5", 8'h01, rd_val)
    wr_bit(8'hD8, 1'b1);
    rd_byte(xirq_pkg::ADDR_AUX_PORT, 1'b1);
    `CHK("rmw latch", 8'h0B, rd_val)
    wr_byte(xirq_pkg::ADDR_AUX_PORT, 8'hFF);
  endtask
  task automatic t_edge_a();
    wr_byte(xirq_pkg::ADDR_CONTROL, 8'h0D);
    src_low <= 4'h4;
    wait_cyc(4);
    `CHK("a edge", 1'b1, irq_a_req)
    `CHK("a prio", 1'b1, irq_a_high_prio)
    src_low <= 4'h0;
    wait_cyc(4);
    `CHK("a held", 1'b1, irq_a_req)
    @(posedge clk_sys);
    ack_a <= 1'b1;
    @(posedge clk_sys);
    ack_a <= 1'b0;
    wait_cyc(1);
    `CHK("a acked", 1'b0, irq_a_req)
    `CHK("vec a", 8'h33, irq_a_vector)
    `CHK("poll a", 3'h6, irq_a_poll)
    `CHK("vec b", 8'h3B, irq_b_vector)
    `CHK("poll b", 3'h7, irq_b_poll)
  endtask
  task automatic t_level_b();
    wr_byte(xirq_pkg::ADDR_CONTROL, 8'h40);
    src_low <= 4'h8;
    wait_cyc(4);
    `CHK("b level", 1'b1, irq_b_req)
    src_low <= 4'h0;
    wait_cyc(4);
    `CHK("b gone", 1'b0, irq_b_req)
  endtask
  task automatic t_edge_b();
    wr_byte(xirq_pkg::ADDR_CONTROL, 8'h50);
    src_low <= 4'h8;
    wait_cyc(4);
    `CHK("b edge", 1'b1, irq_b_req)
    `CHK("b low prio", 1'b0, irq_b_high_prio)
    rd_bit(8'hC5);
    `CHK("b pend bit", 8'h01, rd_val)
    @(posedge clk_sys);
    ack_b <= 1'b1;
    @(posedge clk_sys);
    ack_b <= 1'b0;
    wait_cyc(1);
    `CHK("b acked", 1'b0, irq_b_req)
    src_low <= 4'h0;
    wait_cyc(4);
    `CHK("b rise quiet", 1'b0, irq_b_req)
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_bits();
    t_port();
    t_edge_a();
    t_level_b();
    t_edge_b();
    finish_test();
  end
endmodule
